// File: include/fsps_consts.svh
`ifndef FSPS_CONSTS_SVH
`define FSPS_CONSTS_SVH
// Notes on behaviour
// - In self programming mode, halt starts the loaded flash command.
// - Halt ends by itself when the flash command finishes, no interrupt.
// - Program runs in both modes; halt is plain standby in normal mode.
// - Maskable interrupts are not serviced while self programming mode is on.
// - Internal verify 1 checks a whole block and ends 6.8 ms after halt.
// - Internal verify 2 takes 27 us per verified byte after halt.
// - Block erase clears the chosen block, ending 8.5 ms after its 64-cycle fill that follows halt.
// - Blank check tests the chosen block, ending 480 us after halt.
// - Byte write programs one byte at its address, ending 150 us after halt.
// - Processor stalls during a command; software services watchdog before.
// - Interrupts stay pending in the mode and are served after it ends.
// - Every byte of an erased block reads FFH.
// - First halt after mode entry is released within 10 us plus two clocks.
// - Pins keep their halt standby states during self programming mode.
// - Commands ignore programmer security; protect byte alone blocks erase and write.
// - Mode bit updates after A5H, value, inverse, value; last write counts.
// - Broken sequence leaves mode unchanged and sets status bit 0 error.

`define FSPS_CLK_HZ 40000000
`define FSPS_T_VERIFY1_US 6800
`define FSPS_T_VERIFY2_US 27
`define FSPS_T_ERASE_US 8500
`define FSPS_T_BLANK_US 480
`define FSPS_T_WRITE_US 150
`define FSPS_T_ENTRY_US 10
`define FSPS_CYC(us) ((us) * (`FSPS_CLK_HZ / 1000000))

`define FSPS_OFS_PROTECT_CMD 12'h000
`define FSPS_OFS_STATUS 12'h004
`define FSPS_OFS_MODE_CTRL 12'h008
`define FSPS_OFS_COMMAND 12'h00C
`define FSPS_OFS_ADDR 12'h010
`define FSPS_OFS_ADDR_CMP 12'h014
`define FSPS_OFS_WDATA 12'h018
`define FSPS_OFS_CPU 12'h01C

`define FSPS_KEY 8'hA5
`define FSPS_BLANK 8'hFF
`define FSPS_CMD_VERIFY1 8'h01
`define FSPS_CMD_VERIFY2 8'h02
`define FSPS_CMD_ERASE 8'h03
`define FSPS_CMD_BLANK 8'h04
`define FSPS_CMD_WRITE 8'h05
`define FSPS_BIT_PRERR 0
`define FSPS_BIT_VCERR 1
`define FSPS_BIT_WEPRERR 2
`endif

// File: include/fsps_pkg.sv
package fsps_pkg;
    typedef enum logic [2:0] {
        FSPS_IDLE,
        FSPS_STANDBY,
        FSPS_ENTRY,
        FSPS_EXEC,
        FSPS_ERASE_FILL
    } fsps_state_t;

    typedef enum logic [1:0] {
        FSPS_SEQ_IDLE,
        FSPS_SEQ_KEY,
        FSPS_SEQ_VAL,
        FSPS_SEQ_INV
    } fsps_seq_t;
endpackage : fsps_pkg

// File: verilog/fsps_timer.sv
`timescale 1ns/100ps
`include "fsps_consts.svh"
module fsps_timer
    import fsps_pkg::*;
#(
    parameter int W = 20
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done,
    output logic busy
);
    typedef struct packed
    {
        logic [W-1:0] cnt;
        logic done;
    } fsps_tmr_t;

    fsps_tmr_t r;
    fsps_tmr_t next_r;

    always_comb
    begin
        next_r = r;
        next_r.done = 1'b0;
        if (load)
        begin
            next_r.cnt = count;
        end
        else if (r.cnt == W'(1))
        begin
            next_r.cnt = '0;
            next_r.done = 1'b1;
        end
        else if (r.cnt != '0)
        begin
            next_r.cnt = r.cnt - W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign done = r.done;
    assign busy = (r.cnt != '0);
endmodule : fsps_timer

// File: verilog/fsps_flash.sv
`timescale 1ns/100ps
`include "fsps_consts.svh"
module fsps_flash
    import fsps_pkg::*;
#(
    parameter int AW = 10,
    parameter int BW = 6
)
(
    input wire logic core_clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    // Flash array, power-up content unspecified
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge core_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule : fsps_flash

// File: verilog/fsps_seq.sv
`timescale 1ns/100ps
`include "fsps_consts.svh"
module fsps_seq
    import fsps_pkg::*;
#(
    parameter int AW = 10,
    parameter int BW = 6,
    parameter int TW = 20,
    parameter logic [4:0] PROTECT_BYTE = 5'h00,
    parameter int T_VERIFY1 = `FSPS_CYC(`FSPS_T_VERIFY1_US),
    parameter int T_ERASE = `FSPS_CYC(`FSPS_T_ERASE_US)
)
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_halt_req,
    input wire logic irq_pending_in,
    output logic cpu_halted,
    output logic irq_service_en,
    output logic self_prog_mode,
    output logic pins_hold_standby
);
    localparam int T_VERIFY2 = `FSPS_CYC(`FSPS_T_VERIFY2_US);
    localparam int T_BLANK = `FSPS_CYC(`FSPS_T_BLANK_US);
    localparam int T_WRITE = `FSPS_CYC(`FSPS_T_WRITE_US);
    localparam int T_ENTRY = `FSPS_CYC(`FSPS_T_ENTRY_US);
    localparam int BLK = 1 << BW;

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_s1;
    logic rst_n;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed
    {
        fsps_state_t st;
        fsps_seq_t seq;
        logic mode;
        logic pend_val;
        logic first_halt;
        logic [2:0] err;
        logic [7:0] cmd;
        logic [AW-1:0] addr;
        logic [AW-1:0] addr_cmp;
        logic [7:0] wdata;
        logic [AW-1:0] fill;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic halted;
        logic irq_en;
        logic [TW-1:0] hcnt;
    } fsps_regs_t;

    fsps_regs_t r;
    fsps_regs_t next_r;

    logic tmr_load;
    logic [TW-1:0] tmr_count;
    logic tmr_done;
    logic tmr_busy;
    logic fl_we;
    logic [AW-1:0] fl_waddr;
    logic [7:0] fl_wdata;
    logic [AW-1:0] fl_raddr;
    logic [7:0] fl_rdata;
    logic [AW-1:0] blk_base;
    logic protected_blk;
    logic wr_acc;
    logic rd_acc;

    fsps_timer #(.W(TW)) u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done),
        .busy(tmr_busy)
    );

    fsps_flash #(.AW(AW), .BW(BW)) u_flash (
        .core_clk(core_clk),
        .we(fl_we),
        .waddr(fl_waddr),
        .wdata(fl_wdata),
        .raddr(fl_raddr),
        .rdata(fl_rdata)
    );

    assign blk_base = {r.addr[AW-1:BW], {BW{1'b0}}};
    // Protect byte guards lowest blocks; value is block count
    assign protected_blk = (32'(r.addr[AW-1:BW]) < 32'(PROTECT_BYTE));
    assign wr_acc = psel && penable && pwrite && !r.pready;
    assign rd_acc = psel && penable && !pwrite && !r.pready;
    assign fl_raddr = r.addr;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_r = r;
        next_r.pready = psel && penable && !r.pready;
        next_r.pslverr = 1'b0;
        tmr_load = 1'b0;
        tmr_count = '0;
        fl_we = 1'b0;
        fl_waddr = r.fill;
        fl_wdata = `FSPS_BLANK;
        // Register writes
        if (wr_acc)
        begin
            case (paddr)
                `FSPS_OFS_PROTECT_CMD:
                begin
                    if (r.seq != FSPS_SEQ_IDLE)
                    begin
                        next_r.err[`FSPS_BIT_PRERR] = 1'b1;
                    end
                    next_r.seq = (pwdata[7:0] == `FSPS_KEY) ? FSPS_SEQ_KEY : FSPS_SEQ_IDLE;
                end
                `FSPS_OFS_MODE_CTRL:
                begin
                    case (r.seq)
                        FSPS_SEQ_KEY:
                        begin
                            next_r.pend_val = pwdata[0];
                            next_r.seq = FSPS_SEQ_VAL;
                        end
                        FSPS_SEQ_VAL:
                        begin
                            if (pwdata[0] == !r.pend_val)
                            begin
                                next_r.seq = FSPS_SEQ_INV;
                            end
                            else
                            begin
                                next_r.seq = FSPS_SEQ_IDLE;
                                next_r.err[`FSPS_BIT_PRERR] = 1'b1;
                            end
                        end
                        FSPS_SEQ_INV:
                        begin
                            next_r.seq = FSPS_SEQ_IDLE;
                            if (pwdata[0] == r.pend_val)
                            begin
                                next_r.mode = r.pend_val;
                                next_r.first_halt = r.pend_val;
                            end
                            else
                            begin
                                next_r.err[`FSPS_BIT_PRERR] = 1'b1;
                            end
                        end
                        default:
                        begin
                            next_r.err[`FSPS_BIT_PRERR] = 1'b1;
                        end
                    endcase
                end
                `FSPS_OFS_STATUS:
                begin
                    // Write 0 clears; a write of 1 leaves the flag
                    next_r.err = r.err & pwdata[2:0];
                end
                `FSPS_OFS_COMMAND: next_r.cmd = pwdata[7:0];
                `FSPS_OFS_ADDR: next_r.addr = pwdata[AW-1:0];
                `FSPS_OFS_ADDR_CMP: next_r.addr_cmp = pwdata[AW-1:0];
                `FSPS_OFS_WDATA: next_r.wdata = pwdata[7:0];
                default: next_r.pslverr = 1'b1;
            endcase
            if (paddr != `FSPS_OFS_PROTECT_CMD && paddr != `FSPS_OFS_MODE_CTRL
                && r.seq != FSPS_SEQ_IDLE)
            begin
                next_r.seq = FSPS_SEQ_IDLE;
                next_r.err[`FSPS_BIT_PRERR] = 1'b1;
            end
        end
        // Register reads
        if (rd_acc)
        begin
            case (paddr)
                `FSPS_OFS_STATUS: next_r.prdata = {29'h0, r.err};
                `FSPS_OFS_MODE_CTRL: next_r.prdata = {25'h0, PROTECT_BYTE, 1'b0, r.mode};
                `FSPS_OFS_COMMAND: next_r.prdata = {24'h0, r.cmd};
                `FSPS_OFS_ADDR: next_r.prdata = 32'(r.addr);
                `FSPS_OFS_ADDR_CMP: next_r.prdata = 32'(r.addr_cmp);
                `FSPS_OFS_WDATA: next_r.prdata = {24'h0, fl_rdata};
                `FSPS_OFS_CPU: next_r.prdata = {30'h0, r.halted, 1'b0} | {31'h0, r.mode};
                default:
                begin
                    next_r.prdata = 32'h0;
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        // Halt sequencer
        case (r.st)
            FSPS_IDLE:
            begin
                if (cpu_halt_req)
                begin
                    next_r.halted = 1'b1;
                    if (!r.mode)
                    begin
                        next_r.st = FSPS_STANDBY;
                    end
                    else if (r.first_halt)
                    begin
                        next_r.first_halt = 1'b0;
                        tmr_load = 1'b1;
                        tmr_count = TW'(T_ENTRY);
                        next_r.st = FSPS_ENTRY;
                    end
                    else
                    begin
                        tmr_load = 1'b1;
                        next_r.st = FSPS_EXEC;
                        case (r.cmd)
                            `FSPS_CMD_VERIFY1: tmr_count = TW'(T_VERIFY1);
                            `FSPS_CMD_VERIFY2: tmr_count = TW'((32'(r.addr_cmp - r.addr) + 32'd1) * T_VERIFY2);
                            `FSPS_CMD_ERASE: tmr_count = TW'(T_ERASE);
                            `FSPS_CMD_BLANK: tmr_count = TW'(T_BLANK);
                            `FSPS_CMD_WRITE: tmr_count = TW'(T_WRITE);
                            default: tmr_count = TW'(1);
                        endcase
                        if ((r.cmd == `FSPS_CMD_ERASE || r.cmd == `FSPS_CMD_WRITE) && protected_blk)
                        begin
                            next_r.err[`FSPS_BIT_WEPRERR] = 1'b1;
                        end
                        else if (r.cmd == `FSPS_CMD_ERASE)
                        begin
                            next_r.fill = blk_base;
                            next_r.st = FSPS_ERASE_FILL;
                        end
                        else if (r.cmd == `FSPS_CMD_WRITE)
                        begin
                            fl_we = 1'b1;
                            fl_waddr = r.addr;
                            fl_wdata = r.wdata;
                        end
                    end
                end
            end
            FSPS_STANDBY:
            begin
                if (irq_pending_in)
                begin
                    next_r.halted = 1'b0;
                    next_r.st = FSPS_IDLE;
                end
            end
            FSPS_ERASE_FILL:
            begin
                fl_we = 1'b1;
                next_r.fill = r.fill + AW'(1);
                if (r.fill == blk_base + AW'(BLK - 1))
                begin
                    next_r.st = FSPS_EXEC;
                    tmr_load = 1'b1;
                    tmr_count = TW'(T_ERASE);
                end
            end
            FSPS_ENTRY, FSPS_EXEC:
            begin
                if (tmr_done)
                begin
                    next_r.halted = 1'b0;
                    next_r.st = FSPS_IDLE;
                end
            end
            default: next_r.st = FSPS_IDLE;
        endcase
        next_r.irq_en = !next_r.mode;
        next_r.hcnt = r.halted ? r.hcnt + TW'(1) : '0;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '{st: FSPS_IDLE, seq: FSPS_SEQ_IDLE, irq_en: 1'b1, default: '0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign cpu_halted = r.halted;
    assign irq_service_en = r.irq_en;
    assign self_prog_mode = r.mode;
    assign pins_hold_standby = r.mode;

    ////////////////////////////////////////////////////////////////////////
    a_bad_seq_err: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_acc && paddr == `FSPS_OFS_MODE_CTRL && r.seq == FSPS_SEQ_IDLE)
        |=> r.err[0] && $stable(r.mode)) else $error("broken sequence not flagged");
    a_mode_irq_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        r.mode |-> !irq_service_en) else $error("irq served in mode");
    a_halt_release: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r.st == FSPS_EXEC && tmr_done) |=> !cpu_halted) else $error("halt not released");
    a_entry_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r.st == FSPS_IDLE && cpu_halt_req && r.mode && r.first_halt)
        |-> ##[1:402] !cpu_halted) else $error("entry halt too long");
    a_write_time: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r.st == FSPS_EXEC && r.cmd == `FSPS_CMD_WRITE)
        |-> (tmr_done ? r.hcnt == TW'(T_WRITE) : r.hcnt < TW'(T_WRITE)))
        else $error("write time off");
    a_normal_stby: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r.st == FSPS_IDLE && cpu_halt_req && !r.mode) |=> r.st == FSPS_STANDBY)
        else $error("normal halt ran command");
    a_blank_fill: assert property (@(posedge core_clk) disable iff (!rst_n)
        r.st == FSPS_ERASE_FILL |-> fl_we && fl_wdata == `FSPS_BLANK) else $error("erase not FF");
    a_exec_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r.st == FSPS_IDLE && cpu_halt_req && r.mode && !r.first_halt) |-> tmr_load)
        else $error("command not started");
    c_mode_enter: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(r.mode));
    c_erase: cover property (@(posedge core_clk) disable iff (!rst_n) r.st == FSPS_ERASE_FILL);
    c_seq_err: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(r.err[0]));
endmodule : fsps_seq

// File: sim/fsps_cpu_model.sv
`timescale 1ns/100ps
module fsps_cpu_model (
    input wire logic core_clk,
    input wire logic cpu_halted,
    input wire logic irq_service_en,
    input wire logic irq_src,
    output logic cpu_halt_req,
    output logic irq_pending_in
);
    logic pend = 1'b0;
    initial cpu_halt_req = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // Request held until serviceable
    always @(posedge core_clk)
        pend <= irq_src | (pend & ~(irq_service_en & ~cpu_halted));
    assign irq_pending_in = pend;
    ////////////////////////////////////////////////////////////////////////////////
    // One halt pulse, only while running
    task automatic halt();
        @(posedge core_clk);
        cpu_halt_req <= ~cpu_halted;
        @(posedge core_clk);
        cpu_halt_req <= 1'b0;
    endtask : halt
endmodule : fsps_cpu_model

// File: sim/tb.sv
`timescale 1ns/100ps
`include "fsps_consts.svh"
module tb;
    localparam int TV1 = 50;
    localparam int TER = 50;
    localparam int TW = `FSPS_CYC(`FSPS_T_WRITE_US);
    localparam int TB = `FSPS_CYC(`FSPS_T_BLANK_US);
    localparam int TV2 = 2 * `FSPS_CYC(`FSPS_T_VERIFY2_US);
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, cpu_halt_req, irq_pending_in, cpu_halted;
    logic irq_service_en, self_prog_mode, pins_hold_standby;
    logic irq_src = 1'b0;
    int n_fail = 0;
    int comparisons = 0;
    int hcnt = 0;
    logic [32:0] rq[$];
    logic [63:0] hq[$];
    logic [63:0] lim;
    logic [7:0] wbyte;
    logic [9:0] waddr;

    initial forever #12.5 core_clk = ~core_clk;

    fsps_seq #(.T_VERIFY1(TV1), .T_ERASE(TER)) i_dut (
        .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_halt_req(cpu_halt_req),
        .irq_pending_in(irq_pending_in), .cpu_halted(cpu_halted),
        .irq_service_en(irq_service_en), .self_prog_mode(self_prog_mode),
        .pins_hold_standby(pins_hold_standby)
    );
    fsps_cpu_model i_cpu (
        .core_clk(core_clk), .cpu_halted(cpu_halted), .irq_service_en(irq_service_en),
        .irq_src(irq_src), .cpu_halt_req(cpu_halt_req), .irq_pending_in(irq_pending_in)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_fail++;
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic run(input logic [7:0] c, input int lo, input int hi);
        int n;
        n = 0;
        if (c != 8'h00)
            apb(1'b1, `FSPS_OFS_COMMAND, {24'h0, c});
        hq.push_back({lo[31:0], hi[31:0]});
        i_cpu.halt();
        repeat (2) @(posedge core_clk);
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (cpu_halted === 1'b1 && n < 30000);
        if (n >= 30000)
        begin
            n_fail++;
            complete_run();
        end
        @(posedge core_clk);
    endtask : run

    task automatic mode_seq(input logic v0, input logic v1, input logic v2);
        apb(1'b1, `FSPS_OFS_COMMAND, 32'h0);
        apb(1'b1, `FSPS_OFS_PROTECT_CMD, {24'h0, `FSPS_KEY});
        apb(1'b1, `FSPS_OFS_MODE_CTRL, {31'h0, v0});
        apb(1'b1, `FSPS_OFS_MODE_CTRL, {31'h0, v1});
        apb(1'b1, `FSPS_OFS_MODE_CTRL, {31'h0, v2});
    endtask : mode_seq

    task automatic irq_pulse();
        irq_src <= 1'b1;
        @(posedge core_clk);
        irq_src <= 1'b0;
    endtask : irq_pulse
    ////////////////////////////////////////////////////////////////////////////////
    // Monitor of read answers and halt lengths
    always @(posedge core_clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            check({pslverr, prdata}, rq.size() > 0 ? rq.pop_front() : 'x);
        if (cpu_halted === 1'b1)
            hcnt++;
        else if (hcnt > 0)
        begin
            lim = hq.pop_front();
            check((hcnt >= lim[63:32] && hcnt <= lim[31:0]) ? {1'b0, lim[63:32]} : 33'(hcnt),
                {1'b0, lim[63:32]});
            hcnt = 0;
        end
    end

    initial
    begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        complete_run();
    end

    initial
    begin
        void'($urandom(32'h2A42));
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(`FSPS_OFS_STATUS, 33'h0);
        rd(`FSPS_OFS_MODE_CTRL, 33'h0);
        rd(`FSPS_OFS_CPU, 33'h0);
        rd(12'h0FC, 33'h100000000);
        // Normal mode halt is plain standby
        i_cpu.halt();
        repeat (40) @(posedge core_clk);
        check({32'h0, cpu_halted}, 33'h1);
        check({32'h0, irq_service_en}, 33'h1);
        hq.push_back({32'd40, 32'd50});
        irq_pulse();
        repeat (5) @(posedge core_clk);
        check({32'h0, cpu_halted}, 33'h0);
        // Broken guarded sequence
        apb(1'b1, `FSPS_OFS_PROTECT_CMD, {24'h0, `FSPS_KEY});
        apb(1'b1, `FSPS_OFS_COMMAND, 32'h0);
        rd(`FSPS_OFS_STATUS, 33'h1);
        rd(`FSPS_OFS_MODE_CTRL, 33'h0);
        apb(1'b1, `FSPS_OFS_STATUS, 32'h0);
        rd(`FSPS_OFS_STATUS, 33'h0);
        // Mode write outside a sequence
        apb(1'b1, `FSPS_OFS_MODE_CTRL, 32'h1);
        rd(`FSPS_OFS_STATUS, 33'h1);
        rd(`FSPS_OFS_MODE_CTRL, 33'h0);
        apb(1'b1, `FSPS_OFS_STATUS, 32'h0);
        rd(`FSPS_OFS_STATUS, 33'h0);
        // Enter self programming mode
        mode_seq(1'b1, 1'b0, 1'b1);
        check({32'h0, self_prog_mode}, 33'h1);
        check({32'h0, irq_service_en}, 33'h0);
        check({32'h0, pins_hold_standby}, 33'h1);
        run(8'h00, 1, `FSPS_CYC(`FSPS_T_ENTRY_US) + 2);
        repeat (320) @(posedge core_clk);
        rd(`FSPS_OFS_MODE_CTRL, 33'h1);
        rd(`FSPS_OFS_CPU, 33'h1);
        wbyte = 8'($urandom);
        waddr = {4'h1, 6'($urandom)};
        apb(1'b1, `FSPS_OFS_ADDR, {22'h0, waddr});
        apb(1'b1, `FSPS_OFS_ADDR_CMP, {22'h0, waddr});
        apb(1'b1, `FSPS_OFS_WDATA, {24'h0, wbyte});
        run(`FSPS_CMD_WRITE, TW, TW + 4);
        rd(`FSPS_OFS_WDATA, {25'h0, wbyte});
        repeat (2) run(`FSPS_CMD_ERASE, TER + 64, TER + 68);
        rd(`FSPS_OFS_WDATA, {25'h0, `FSPS_BLANK});
        run(`FSPS_CMD_BLANK, TB, TB + 4);
        run(`FSPS_CMD_VERIFY1, TV1, TV1 + 4);
        apb(1'b1, `FSPS_OFS_ADDR, 32'h40);
        apb(1'b1, `FSPS_OFS_ADDR_CMP, 32'h41);
        run(`FSPS_CMD_VERIFY2, TV2, TV2 + 4);
        // Interrupt held while in the mode
        irq_pulse();
        repeat (3) @(posedge core_clk);
        check({32'h0, irq_service_en}, 33'h0);
        mode_seq(1'b0, 1'b1, 1'b0);
        rd(`FSPS_OFS_MODE_CTRL, 33'h0);
        check({32'h0, self_prog_mode}, 33'h0);
        check({32'h0, irq_service_en}, 33'h1);
        check({32'h0, pins_hold_standby}, 33'h0);
        repeat (2) @(posedge core_clk);
        check({32'h0, irq_pending_in}, 33'h0);
        repeat (5) @(posedge core_clk);
        complete_run();
    end
endmodule : tb
